// [inc/fbh_pkg.sv]
package fbh_pkg;
    // bus widths
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    // command codes
    localparam logic [7:0] CMD_SET_READ  = 8'h00;
    localparam logic [7:0] CMD_SIGNATURE = 8'h90;
    localparam logic [7:0] CMD_ERASE     = 8'h20;
    localparam logic [7:0] CMD_ERASE_VFY = 8'hA0;
    localparam logic [7:0] CMD_PROGRAM   = 8'h40;
    localparam logic [7:0] CMD_PROG_VFY  = 8'hC0;
    localparam logic [7:0] CMD_RESET     = 8'hFF;
    localparam logic [7:0] ERASED_BYTE   = 8'hFF;
    // timing, figures in their own units
    localparam int CLK_NS          = 10;
    localparam int T_PROG_US       = 10;
    localparam int T_ERASE_US_X10  = 95000;   // 9.5 ms in tenths of us
    localparam int T_RECOVERY_US   = 6;
    localparam int T_STROBE_NS     = 40;
    localparam int T_WE_HIGH_NS    = 20;
    localparam int PROG_CYC  = (T_PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_CYC = (T_ERASE_US_X10 * 100 + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC   = (T_RECOVERY_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int STB_CYC   = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WEH_CYC   = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int MAX_LOOPS = 25;
    localparam int CNT_W     = 24;
    localparam logic [4:0] LOOP_LIMIT = 5'(MAX_LOOPS);
    // host operations
    typedef enum logic [2:0] {
        FBH_OP_READ    = 3'h0,
        FBH_OP_PROGRAM = 3'h1,
        FBH_OP_ERASE   = 3'h2,
        FBH_OP_SIG     = 3'h3,
        FBH_OP_RESET   = 3'h4
    } fbh_op_e;
    typedef struct packed {
        fbh_op_e             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } fbh_req_s;
    typedef struct packed {
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic                vpp_high;
        logic [ADDR_W-1:0]   addr;
    } fbh_pins_s;
endpackage : fbh_pkg

// [src/fbh_timer.sv]
`timescale 1ns/1ps
// loadable down counter; done pulses one cycle when it reaches zero
module fbh_timer
    import fbh_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] count,
    output logic                  busy,
    output logic                  done
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             done_next;

    // load wins over counting so a restart never finishes early
    always_comb begin
        cnt_next  = cnt_reg;
        done_next = 1'b0;
        if (load) begin
            cnt_next = count;
        end else if (cnt_reg != '0) begin
            cnt_next  = cnt_reg - CNT_W'(1);
            done_next = (cnt_reg == CNT_W'(1));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            done    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            done    <= done_next;
        end
    end

    assign busy = (cnt_reg != '0);
endmodule : fbh_timer

// [src/fbh_host.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Operation
// - read by driving chip select and output drive low, write strobe high
// - with program supply high, issue set-read before array reads
// - chip erase needs the erase code written twice in a row
// - host waits at least 6 us after write strobe rise before reading
// - host allows at most 25 program-verify loops per byte
module fbh_host
    import fbh_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire fbh_req_s          req,
    input  wire logic              req_valid,
    output logic                   req_ready,
    output logic                   resp_valid,
    output logic [DATA_W-1:0]      resp_data,
    output logic                   resp_fail,
    output fbh_pins_s              pins,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe,
    input  wire logic [DATA_W-1:0] dq_in
);
    typedef enum logic [3:0] {
        FBH_IDLE   = 4'h0,
        FBH_WLOW   = 4'h1,
        FBH_WHIGH  = 4'h3,
        FBH_WAIT   = 4'h2,
        FBH_DECIDE = 4'h6,
        FBH_RLOW   = 4'h7,
        FBH_DONE   = 4'h5
    } fbh_state_e;

    // phases: which write of the sequence is in flight
    typedef enum logic [2:0] {
        PH_CMD1 = 3'h0, PH_CMD2 = 3'h1, PH_VFY = 3'h2,
        PH_READ = 3'h3, PH_SET  = 3'h4
    } fbh_phase_e;

    fbh_state_e        st_reg, st_next;
    fbh_phase_e        ph_reg, ph_next;
    fbh_req_s          cur_reg, cur_next;
    logic [4:0]        loops_reg, loops_next;
    logic [CNT_W-1:0]  tcount;
    logic              tload, tbusy, tdone;
    fbh_pins_s         pins_next;
    logic [DATA_W-1:0] dq_next, rdata_next;
    logic              oe_next, ready_next, rv_next, fail_next;

    fbh_timer u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .load    (tload),
        .count   (tcount),
        .busy    (tbusy),
        .done    (tdone)
    );

    // command byte for the write in the current phase
    function automatic logic [7:0] cmd_byte(input fbh_req_s r,
                                            input fbh_phase_e p);
        logic [7:0] b;
        b = CMD_SET_READ;
        case (r.op)
            FBH_OP_PROGRAM: b = (p == PH_CMD1) ? CMD_PROGRAM :
                                (p == PH_CMD2) ? r.data : CMD_PROG_VFY;
            FBH_OP_ERASE:   b = (p == PH_VFY) ? CMD_ERASE_VFY : CMD_ERASE;
            FBH_OP_SIG:     b = CMD_SIGNATURE;
            FBH_OP_RESET:   b = CMD_RESET;
            default:        b = CMD_SET_READ;
        endcase
        return b;
    endfunction : cmd_byte

    ////////////////////////////////////////////////////////////////////////
    // sequencer: one write or read cycle at a time
    always_comb begin
        st_next    = st_reg;
        ph_next    = ph_reg;
        cur_next   = cur_reg;
        loops_next = loops_reg;
        pins_next  = pins;
        dq_next    = dq_out;
        oe_next    = dq_oe;
        rdata_next = resp_data;
        ready_next = 1'b0;
        rv_next    = 1'b0;
        fail_next  = resp_fail;
        tload      = 1'b0;
        tcount     = '0;
        case (st_reg)
            FBH_IDLE: begin
                ready_next = 1'b1;
                pins_next.ce_n = 1'b1;         // standby between ops
                pins_next.oe_n = 1'b1;
                pins_next.we_n = 1'b1;
                oe_next = 1'b0;
                if (req_valid && req_ready) begin
                    cur_next   = req;
                    loops_next = '0;
                    ready_next = 1'b0;
                    fail_next  = 1'b0;
                    // reads start with set-read under high supply
                    ph_next    = PH_CMD1;
                    st_next    = FBH_WLOW;
                    pins_next.vpp_high = 1'b1; // writes need high supply
                    tload  = 1'b1;
                    tcount = CNT_W'(STB_CYC);
                end
            end
            FBH_WLOW: begin
                // write strobe low, output drive high
                pins_next.ce_n = 1'b0;
                pins_next.oe_n = 1'b1;
                pins_next.we_n = 1'b0;
                // address for erase verify or program target
                pins_next.addr = (ph_reg == PH_CMD2 ||
                    (ph_reg == PH_VFY && cur_reg.op == FBH_OP_ERASE))
                    ? cur_reg.addr : '0;
                dq_next = cmd_byte(cur_reg, ph_reg);
                oe_next = 1'b1;
                if (!tbusy && !tload && pins.we_n == 1'b0) begin
                    st_next = FBH_WHIGH;           // rise captures byte
                    pins_next.we_n = 1'b1;
                    tload  = 1'b1;
                    tcount = CNT_W'(WEH_CYC);
                end
            end
            FBH_WHIGH: begin
                if (!tbusy && !tload) begin
                    oe_next = 1'b0;
                    st_next = FBH_WAIT;
                    tload   = 1'b1;
                    // pulse lengths wait out the internal timers
                    if (ph_reg == PH_CMD2 && cur_reg.op == FBH_OP_PROGRAM)
                        tcount = CNT_W'(PROG_CYC);
                    else if (ph_reg == PH_CMD2 &&
                             cur_reg.op == FBH_OP_ERASE)
                        tcount = CNT_W'(ERASE_CYC);
                    else
                        tcount = CNT_W'(REC_CYC);
                end
            end
            FBH_WAIT: begin
                if (!tbusy && !tload) begin
                    st_next = FBH_DECIDE;
                end
            end
            FBH_DECIDE: begin
                st_next = FBH_WLOW;
                tload   = 1'b1;
                tcount  = CNT_W'(STB_CYC);
                case (cur_reg.op)
                    // erase and reset both write the code twice
                    FBH_OP_ERASE, FBH_OP_PROGRAM, FBH_OP_RESET: begin
                        if (ph_reg == PH_CMD1)
                            ph_next = PH_CMD2;
                        else if (ph_reg == PH_CMD2 &&
                                 cur_reg.op != FBH_OP_RESET)
                            ph_next = PH_VFY;       // verify ends pulse
                        else if (ph_reg == PH_VFY)
                            st_next = FBH_RLOW;
                        else
                            st_next = FBH_DONE;
                    end
                    default: st_next = FBH_RLOW;
                endcase
            end
            FBH_RLOW: begin
                // read: chip select and output drive low, write high
                pins_next.ce_n = 1'b0;
                pins_next.oe_n = 1'b0;
                pins_next.we_n = 1'b1;
                oe_next = 1'b0;
                pins_next.addr = (cur_reg.op == FBH_OP_READ ||
                                  cur_reg.op == FBH_OP_SIG)
                                 ? cur_reg.addr : pins.addr;
                if (!tbusy && !tload && pins.oe_n == 1'b0) begin
                    rdata_next = dq_in;
                    st_next    = FBH_DONE;
                    pins_next.oe_n = 1'b1;
                    if (cur_reg.op == FBH_OP_PROGRAM &&
                        dq_in != cur_reg.data) begin
                        loops_next = loops_reg + 5'h01;
                        // bounded retry count
                        if (loops_reg + 5'h01 >= LOOP_LIMIT) begin
                            fail_next = 1'b1;
                        end else begin
                            st_next = FBH_WLOW;
                            ph_next = PH_CMD1;
                            tload   = 1'b1;
                            tcount  = CNT_W'(STB_CYC);
                        end
                    end else if (cur_reg.op == FBH_OP_ERASE &&
                                 dq_in != ERASED_BYTE) begin
                        fail_next = 1'b1; // software preprograms
                    end
                end
            end
            FBH_DONE: begin
                pins_next.ce_n = 1'b1;
                pins_next.oe_n = 1'b1;
                pins_next.we_n = 1'b1;
                pins_next.vpp_high = 1'b0;
                rv_next = 1'b1;
                st_next = FBH_IDLE;
            end
            default: st_next = FBH_IDLE;
        endcase
    end

    // registers only; all outputs come from flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg     <= FBH_IDLE;
            ph_reg     <= PH_CMD1;
            cur_reg    <= '0;
            loops_reg  <= '0;
            pins       <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                            vpp_high: 1'b0, addr: '0};
            dq_out     <= '0;
            dq_oe      <= 1'b0;
            resp_data  <= '0;
            req_ready  <= 1'b0;
            resp_valid <= 1'b0;
            resp_fail  <= 1'b0;
        end else begin
            st_reg     <= st_next;
            ph_reg     <= ph_next;
            cur_reg    <= cur_next;
            loops_reg  <= loops_next;
            pins       <= pins_next;
            dq_out     <= dq_next;
            dq_oe      <= oe_next;
            resp_data  <= rdata_next;
            req_ready  <= ready_next;
            resp_valid <= rv_next;
            resp_fail  <= fail_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_read_levels: assert property (@(posedge sys_clk)
        disable iff (!rst_n) !pins.oe_n |-> !pins.ce_n && pins.we_n && !dq_oe)
        else $error("read strobes wrong");
    chk_write_supply: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        !pins.we_n |-> (pins.vpp_high && dq_oe && pins.oe_n))
        else $error("write without high supply");
    chk_no_contend: assert property (@(posedge sys_clk)
        disable iff (!rst_n) dq_oe |-> pins.oe_n)
        else $error("bus contention");
    chk_strobe_width: assert property (@(posedge sys_clk)
        disable iff (!rst_n) $fell(pins.we_n) |-> !pins.we_n [*4])
        else $error("write strobe too short");
    chk_recovery_wait: assert property (@(posedge sys_clk)
        disable iff (!rst_n) $rose(pins.we_n) |-> pins.oe_n [*8])
        else $error("read too soon after write");
    chk_idle_standby: assert property (@(posedge sys_clk)
        disable iff (!rst_n) req_ready |-> pins.ce_n)
        else $error("not standby while idle");
    chk_loop_bound: assert property (@(posedge sys_clk)
        disable iff (!rst_n) loops_reg <= LOOP_LIMIT)
        else $error("too many program loops");
    chk_resp_after_done: assert property (@(posedge sys_clk)
        disable iff (!rst_n) st_reg == FBH_DONE |=> resp_valid ##1 req_ready)
        else $error("response sequence wrong");
    cov_program: cover property (@(posedge sys_clk) disable iff (!rst_n)
        resp_valid && cur_reg.op == FBH_OP_PROGRAM);
    cov_erase: cover property (@(posedge sys_clk) disable iff (!rst_n)
        resp_valid && cur_reg.op == FBH_OP_ERASE);
    cov_retry: cover property (@(posedge sys_clk) disable iff (!rst_n)
        loops_reg == 5'h02);
endmodule : fbh_host

// [dv/fbh_flash_model.sv]
`timescale 1ns/1ps
// behavioural flash device facing the host; counts host-side slips
module fbh_flash_model
    import fbh_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] PART_CODE  = 8'hC3  // arbitrary value
)(
    input  wire fbh_pins_s         pins,
    input  wire logic [DATA_W-1:0] dq_wire,
    input  wire logic              prog_stuck,
    output logic [DATA_W-1:0]      dev_q,
    output logic [15:0]            viol_cnt,
    output logic [15:0]            prog_cnt,
    output logic [15:0]            reset_cnt
);
    typedef enum logic [1:0] {M_ARRAY, M_SIG, M_PVFY, M_EVFY} fbh_mode_e;
    typedef enum logic [1:0] {P_NONE, P_ERASE, P_PROG, P_RESET} fbh_pend_e;
    logic [7:0]        mem [0:(1<<ADDR_W)-1];
    fbh_mode_e         mode;
    fbh_pend_e         pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] prog_addr;
    logic [ADDR_W-1:0] vfy_addr;
    logic [7:0]        rd_val;
    logic [7:0]        last_q;
    logic              drive;
    logic              fresh_vpp;
    realtime           t_we_rise;
    realtime           t_prog_end;
    ////////////////////////////////////////////////////////////////////////
    // power-up: array read mode, erased contents
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = ERASED_BYTE;
        mode = M_ARRAY;
        pend = P_NONE;
        {viol_cnt, prog_cnt, reset_cnt} = '0;
        {last_q, fresh_vpp, wr_addr, prog_addr, vfy_addr} = '0;
        t_we_rise = 0.0;
        t_prog_end = 0.0;
    end
    // supply raised: host owes a command write before reading
    always @(posedge pins.vpp_high) fresh_vpp = 1'b1;
    // address latched on falling strobe; a write inside the program pulse counts as a slip
    always @(negedge pins.we_n) if (!pins.ce_n) begin
        wr_addr = pins.addr;
        if ($realtime < t_prog_end) viol_cnt++;
    end
    // command byte taken on rising strobe, only with supply high
    always @(posedge pins.we_n) if (!pins.ce_n) begin
        t_we_rise = $realtime;
        if (!pins.vpp_high) viol_cnt++;
        else begin
            fresh_vpp = 1'b0;
            case (pend)
                P_PROG: begin
                    if (!prog_stuck) mem[wr_addr] = mem[wr_addr] & dq_wire;
                    prog_addr = wr_addr;
                    t_prog_end = $realtime + 10000.0;
                    pend = P_NONE;
                end
                P_ERASE, P_RESET: begin // mismatch keeps the mode
                    if (pend == P_ERASE && dq_wire == CMD_ERASE)
                        for (int i = 0; i < (1 << ADDR_W); i++)
                            mem[i] = ERASED_BYTE;
                    if (pend == P_RESET && dq_wire == CMD_RESET) begin
                        reset_cnt++;
                        mode = M_ARRAY;
                    end
                    pend = P_NONE;
                end
                default: case (dq_wire)
                    CMD_SET_READ:  mode = M_ARRAY;
                    CMD_SIGNATURE: mode = M_SIG;
                    CMD_ERASE:     pend = P_ERASE;
                    CMD_PROGRAM: begin
                        pend = P_PROG;
                        prog_cnt++;
                    end
                    CMD_PROG_VFY:  mode = M_PVFY;
                    CMD_ERASE_VFY: begin
                        mode = M_EVFY;
                        vfy_addr = wr_addr;
                    end
                    CMD_RESET:     pend = P_RESET;
                    default:       ;
                endcase
            endcase
        end
    end
    // read data by mode
    always_comb begin
        case (mode)
            M_SIG:   rd_val = pins.addr[0] ? PART_CODE : MAKER_CODE;
            M_PVFY:  rd_val = mem[prog_addr];
            M_EVFY:  rd_val = mem[vfy_addr];
            default: rd_val = mem[pins.addr];
        endcase
    end
    assign drive = !pins.ce_n && !pins.oe_n && pins.we_n;
    // no pull on the bus: a released line shows the inverse of its last value
    assign dev_q = drive ? rd_val : ~last_q;
    always @(negedge drive) last_q = rd_val;
    // read too soon after a write, or with no write since supply rose, is a host slip
    always @(posedge drive) begin
        if (t_we_rise > 0.0 && $realtime - t_we_rise < 6000.0)
            viol_cnt++;
        if (pins.vpp_high && fresh_vpp) viol_cnt++;
    end
endmodule : fbh_flash_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import fbh_pkg::*;
    // failing program (25 loops) dominates the run
    localparam int         TIMEOUT_CYC = 90000;
    localparam logic [7:0] MAKER       = 8'h5A;
    localparam logic [7:0] PART        = 8'hC3;
    logic              sys_clk, rst_n, req_valid, req_ready;
    logic              resp_valid, resp_fail, dq_oe, prog_stuck, got_fail;
    fbh_req_s          req;
    fbh_pins_s         pins;
    logic [DATA_W-1:0] resp_data, dq_out, dev_q, dq_wire, got_data;
    logic [15:0]       viol_cnt, prog_cnt, reset_cnt, cnt0;
    int                err_total, n_tests, cycles;

    fbh_host uut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
        .req_valid(req_valid), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_data(resp_data),
        .resp_fail(resp_fail), .pins(pins), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_wire));
    fbh_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (
        .pins(pins), .dq_wire(dq_wire), .prog_stuck(prog_stuck),
        .dev_q(dev_q), .viol_cnt(viol_cnt), .prog_cnt(prog_cnt),
        .reset_cnt(reset_cnt));
    // wire level: host wins while it drives
    assign dq_wire = dq_oe ? dq_out : dev_q;
    ////////////////////////////////////////////////////////////////////////
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= TIMEOUT_CYC) begin
            err_total++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic check8(input logic [7:0] got, exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got,
                     exp);
        end
    endtask : check8
    task automatic check1(input logic got, exp, input string msg);
        check8({7'h00, got}, {7'h00, exp}, msg);
    endtask : check1
    // one request: held until taken, then wait the one-cycle answer
    task automatic run_op(input fbh_op_e op, input logic [17:0] a,
                          input logic [7:0] d);
        int n;
        n = 0;
        req = '{op: op, addr: a, data: d};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 70000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        got_data = resp_data;
        got_fail = resp_fail;
        check1(resp_valid, 1'b1, "no answer");
    endtask : run_op
    ////////////////////////////////////////////////////////////////////////
    task automatic t_idle;
        check1(pins.ce_n, 1'b1, "idle select");
        check1(pins.vpp_high, 1'b0, "idle supply");
        check1(dq_oe, 1'b0, "idle drive");
        check1(req_ready, 1'b1, "idle ready");
        $display("test idle done");
    endtask : t_idle
    task automatic t_read;
        u_flash.mem[18'h3FFFF] = 8'hA5;
        u_flash.mem[18'h00000] = 8'h3C;
        run_op(FBH_OP_READ, 18'h3FFFF, 8'h00);
        check8(got_data, 8'hA5, "read top");
        run_op(FBH_OP_READ, 18'h00000, 8'h00);
        check8(got_data, 8'h3C, "read bottom");
        $display("test read done");
    endtask : t_read
    task automatic t_sig;
        run_op(FBH_OP_SIG, 18'h00000, 8'h00);
        check8(got_data, MAKER, "maker code");
        run_op(FBH_OP_SIG, 18'h00001, 8'h00);
        check8(got_data, PART, "part code");
        $display("test signature done");
    endtask : t_sig
    task automatic t_prog;
        cnt0 = prog_cnt;
        run_op(FBH_OP_PROGRAM, 18'h12345, 8'h5A);
        check1(got_fail, 1'b0, "program fail");
        check8(8'(prog_cnt - cnt0), 8'h01, "program loops");
        run_op(FBH_OP_READ, 18'h12345, 8'h00);
        check8(got_data, 8'h5A, "program readback");
        $display("test program done");
    endtask : t_prog
    // device never takes the byte: host must give up after 25 loops
    task automatic t_prog_fail;
        prog_stuck = 1'b1;
        cnt0 = prog_cnt;
        run_op(FBH_OP_PROGRAM, 18'h00777, 8'h00);
        check1(got_fail, 1'b1, "stuck fail");
        check8(8'(prog_cnt - cnt0), 8'(MAX_LOOPS), "stuck loops");
        prog_stuck = 1'b0;
        run_op(FBH_OP_READ, 18'h00777, 8'h00);
        check8(got_data, ERASED_BYTE, "stuck readback");
        check1(got_fail, 1'b0, "fail cleared");
        $display("test program failure done");
    endtask : t_prog_fail
    task automatic t_reset;
        cnt0 = reset_cnt;
        run_op(FBH_OP_RESET, 18'h00000, 8'h00);
        check8(8'(reset_cnt - cnt0), 8'h01, "reset count");
        run_op(FBH_OP_READ, 18'h3FFFF, 8'h00);
        check8(got_data, 8'hA5, "read after reset");
        $display("test reset done");
    endtask : t_reset
    // a controller reset in mid-pulse cuts a chip erase short
    task automatic t_erase_abort;
        req = '{op: FBH_OP_ERASE, addr: 18'h12345, data: 8'h00};
        req_valid = 1'b1;
        wait (req_ready === 1'b1);
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        repeat (1500) @(posedge sys_clk);
        #1;
        check1(pins.vpp_high, 1'b1, "erase supply");
        check1(pins.we_n, 1'b1, "erase strobe idle");
        rst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_idle();
        run_op(FBH_OP_READ, 18'h12345, 8'h00);
        check8(got_data, ERASED_BYTE, "erased byte");
        $display("test erase abort done");
    endtask : t_erase_abort
    ////////////////////////////////////////////////////////////////////////
    // a full erase pulse outlasts the run budget, so a reset cuts it short
    initial begin
        {sys_clk, rst_n, req_valid, prog_stuck} = '0;
        req = '0;
        {err_total, n_tests, cycles} = '0;
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_idle();
        t_read();
        t_sig();
        t_prog();
        t_prog_fail();
        t_reset();
        t_erase_abort();
        check8(viol_cnt[7:0], 8'h00, "host slips");
        end_of_test();
    end
endmodule : testbench
